// ---- inc/pin_group_if.sv ----
// Purpose: carries watched pin change events between detector and top
// Assumes: one clock
// Notes:   events are one-cycle pulses per group
`timescale 1ns/100ps
interface pin_group_if;
    import watched_pin_pkg::*;
    pins_t  pin_mask;
    group_t group_event;
    modport det (input pin_mask, output group_event);
    modport top (output pin_mask, input group_event);
endinterface

// ---- inc/watched_pin_params.svh ----
// Purpose: offsets, field positions, reset values of the pin change interrupt unit
// Assumes: avalon-mm byte addresses, one register per 32-bit word
// Notes:   printed offsets are not all multiples of four, so they are word indices
`ifndef WATCHED_PIN_PARAMS_SVH
`define WATCHED_PIN_PARAMS_SVH
`define IDX_GROUP_ENABLE   8'h68
`define IDX_GROUP0_MASK    8'h6b
`define IDX_GROUP1_MASK    8'h6c
`define IDX_GROUP2_MASK    8'h6d
`define IDX_GROUP_FLAGS    8'h6e
`define IDX_CPU_CTRL       8'h6f
`define IDX_IRQ_MASK       8'h70
`define GROUP_FIELD_W      3
`define GROUP1_MASK_BITS   8'h7f
`define RESET_BYTE         8'h00
`define GLOBAL_EN_BIT      0
`endif

// ---- inc/watched_pin_pkg.sv ----
// Purpose: shared types of the pin change interrupt unit
// Assumes: three pin groups
// Notes:   constants live in watched_pin_params.svh
package watched_pin_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [2:0]  group_t;
    typedef logic [23:0] pins_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_e;
endpackage

// ---- rtl/group_vector_arb.sv ----
// Purpose: picks the vector to request from pending enabled groups
// Assumes: lower group number has priority
// Notes:   combinational helper, outputs registered in top
`timescale 1ns/100ps
module group_vector_arb (
    input  wire watched_pin_pkg::group_t pending,
    output logic [1:0]             vec_num,
    output logic                   vec_valid
);
    import watched_pin_pkg::*;
    assign vec_valid = |pending;
    assign vec_num   = pending[0] ? 2'h0 : (pending[1] ? 2'h1 : (pending[2] ? 2'h2 : 2'h0));
endmodule

// ---- rtl/pin_change_detect.sv ----
// Purpose: synchronise pins and flag changes on masked pins per group
// Assumes: pins asynchronous to sys_clk are treated as level inputs
// Notes:   two-flop synchroniser then a compare stage
`timescale 1ns/100ps
module pin_change_detect (
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    input  wire watched_pin_pkg::pins_t watched_pin,
    pin_group_if.det           grp
);
    import watched_pin_pkg::*;
    pins_t sync1_ff;
    pins_t sync2_ff;
    pins_t prev_ff;
    group_t evt_ff;
    wire pins_t changed = (sync2_ff ^ prev_ff) & grp.pin_mask;
    wire group_t nxt_evt = {|changed[23:16], |changed[14:8], |changed[7:0]};
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
            evt_ff   <= '0;
        end else begin
            sync1_ff <= watched_pin;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
            evt_ff   <= nxt_evt;
        end
    end
    assign grp.group_event = evt_ff;
    chk_change_to_event: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (|changed) |=> (|evt_ff)) else $error("masked change lost");
endmodule

// ---- rtl/pin_change_irq.sv ----
// Purpose: pin change interrupt unit with avalon-mm register slave
// Assumes: pins synchronous by two flops inside; cpu acknowledges vector entry
// Notes:   irq is a level; vec_req reflects flag, group enable and global enable
// Behaviour
// - bits 7:3 of group enable and group flag registers read as zero.
// - group 2 enabled with global enable requests vector 2 on a masked pin 23:16 change.
// - group 1 enabled with global enable requests vector 1 on a masked pin 14:8 change.
// - group 0 enabled with global enable requests vector 0 on a masked pin 7:0 change.
// - a masked change sets the group flag bit 2, 1 or 0 for its pin group.
// - a set flag requests its vector only while global and group enables are set.
// - entering a group's service routine clears that group's flag.
// - writing one to a flag bit clears it, writing zero leaves it.
// - each group 2 mask bit enables change detection on its pin.
// - group 1 mask uses bits 6:0 for pins 14:8 and bit 7 reads zero.
// - each group 0 mask bit enables change detection on its pin.
`timescale 1ns/100ps
`include "watched_pin_params.svh"
module pin_change_irq (
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic [9:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire watched_pin_pkg::pins_t   watched_pin,
    input  wire watched_pin_pkg::group_t  vector_ack,
    output watched_pin_pkg::group_t       vector_req,
    output logic [1:0]              vector_num,
    output logic                    irq
);
    import watched_pin_pkg::*;

    pin_group_if grp ();

    byte_t      group_enable_reg_ff;
    byte_t      group_flag_reg_ff;
    byte_t      group0_mask_reg_ff;
    byte_t      group1_mask_reg_ff;
    byte_t      group2_mask_reg_ff;
    byte_t      irq_mask_ff;
    logic       global_en_ff;
    bus_state_e bus_ff;
    logic       wait_req_ff;
    logic [31:0] rdata_ff;
    group_t     vreq_ff;
    logic [1:0] vnum_ff;
    logic       irq_ff;

    // word index from byte address; avalon words are 4 bytes
    wire logic [7:0] idx      = avs_address[9:2];
    // writes land at the edge that ends the answer cycle, the one the master samples
    wire logic       ack_cyc  = (bus_ff == BUS_ACK);
    wire logic       wr_lane0 = ack_cyc & avs_write & avs_byteenable[0];
    wire byte_t      wbyte    = avs_writedata[7:0];

    wire logic hit_en   = (idx == `IDX_GROUP_ENABLE);
    wire logic hit_m0   = (idx == `IDX_GROUP0_MASK);
    wire logic hit_m1   = (idx == `IDX_GROUP1_MASK);
    wire logic hit_m2   = (idx == `IDX_GROUP2_MASK);
    wire logic hit_flag = (idx == `IDX_GROUP_FLAGS);
    wire logic hit_cpu  = (idx == `IDX_CPU_CTRL);
    wire logic hit_im   = (idx == `IDX_IRQ_MASK);

    // masks gated by group enables feed the detector
    assign grp.pin_mask = {group2_mask_reg_ff & {8{group_enable_reg_ff[2]}},
                           1'b0,
                           group1_mask_reg_ff[6:0] & {7{group_enable_reg_ff[1]}},
                           group0_mask_reg_ff & {8{group_enable_reg_ff[0]}}};

    pin_change_detect u_detect (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .watched_pin (watched_pin),
        .grp         (grp.det)
    );

    // set wins over both software and vector-entry clears
    wire group_t sw_clr  = (wr_lane0 & hit_flag) ? wbyte[2:0] : 3'h0;
    wire group_t clr_all = sw_clr | vector_ack;
    wire group_t nxt_flags = (group_flag_reg_ff[2:0] & ~clr_all) | grp.group_event;

    // a flag only requests a vector with both enables set
    wire group_t pending = group_flag_reg_ff[2:0] & group_enable_reg_ff[2:0]
                           & {3{global_en_ff}};
    wire logic [1:0] arb_num;
    wire logic       arb_valid;

    group_vector_arb u_arb (
        .pending   (pending),
        .vec_num   (arb_num),
        .vec_valid (arb_valid)
    );

    wire logic nxt_irq = |(group_flag_reg_ff[2:0] & irq_mask_ff[2:0]);

    wire logic [31:0] rd_mux =
        hit_en   ? {24'h0, 5'h0, group_enable_reg_ff[2:0]} :
        hit_flag ? {24'h0, 5'h0, group_flag_reg_ff[2:0]} :
        hit_m0   ? {24'h0, group0_mask_reg_ff} :
        hit_m1   ? {24'h0, group1_mask_reg_ff & `GROUP1_MASK_BITS} :
        hit_m2   ? {24'h0, group2_mask_reg_ff} :
        hit_cpu  ? {31'h0, global_en_ff} :
        hit_im   ? {29'h0, irq_mask_ff[2:0]} :
                   32'h0;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            group_enable_reg_ff <= `RESET_BYTE;
            group0_mask_reg_ff  <= `RESET_BYTE;
            group1_mask_reg_ff  <= `RESET_BYTE;
            group2_mask_reg_ff  <= `RESET_BYTE;
            irq_mask_ff         <= `RESET_BYTE;
            global_en_ff        <= 1'b0;
        end else if (wr_lane0) begin
            if (hit_en) begin
                group_enable_reg_ff <= {5'h0, wbyte[2:0]};
            end else if (hit_m0) begin
                group0_mask_reg_ff <= wbyte;
            end else if (hit_m1) begin
                group1_mask_reg_ff <= wbyte & `GROUP1_MASK_BITS;
            end else if (hit_m2) begin
                group2_mask_reg_ff <= wbyte;
            end else if (hit_cpu) begin
                global_en_ff <= wbyte[`GLOBAL_EN_BIT];
            end else if (hit_im) begin
                irq_mask_ff <= {5'h0, wbyte[2:0]};
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            group_flag_reg_ff <= `RESET_BYTE;
        end else begin
            group_flag_reg_ff <= {5'h0, nxt_flags};
        end
    end

    // one wait cycle: request taken in idle, answer in ack state
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_ff      <= BUS_IDLE;
            wait_req_ff <= 1'b1;
            rdata_ff    <= 32'h0;
        end else begin
            case (bus_ff)
                BUS_IDLE: begin
                    if (avs_read | avs_write) begin
                        bus_ff      <= BUS_ACK;
                        wait_req_ff <= 1'b0;
                        rdata_ff    <= avs_read ? rd_mux : 32'h0;
                    end
                end
                BUS_ACK: begin
                    bus_ff      <= BUS_IDLE;
                    wait_req_ff <= 1'b1;
                end
                default: begin
                    bus_ff      <= BUS_IDLE;
                    wait_req_ff <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vreq_ff <= 3'h0;
            vnum_ff <= 2'h0;
            irq_ff  <= 1'b0;
        end else begin
            vreq_ff <= pending & ~vector_ack;
            vnum_ff <= arb_valid ? arb_num : vnum_ff;
            irq_ff  <= nxt_irq;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_req_ff;
    assign vector_req      = vreq_ff;
    assign vector_num      = vnum_ff;
    assign irq             = irq_ff;

    sequence s_flag_set(int g);
        grp.group_event[g] ##1 group_flag_reg_ff[g];
    endsequence

    chk_flag_set_g0: assert property (@(posedge sys_clk) disable iff (sys_rst)
        grp.group_event[0] |=> group_flag_reg_ff[0]) else $error("flag 0 not set");
    chk_flag_set_g2: assert property (@(posedge sys_clk) disable iff (sys_rst)
        grp.group_event[2] |-> s_flag_set(2)) else $error("flag 2 not set");
    chk_upper_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        group_flag_reg_ff[7:3] == 5'h0 && group_enable_reg_ff[7:3] == 5'h0)
        else $error("reserved bits set");
    chk_w1c_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (sw_clr[1] && !grp.group_event[1]) |=> !group_flag_reg_ff[1])
        else $error("w1c failed");
    chk_ack_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (vector_ack != 3'h0)
        |=> ((group_flag_reg_ff[2:0] & $past(vector_ack & ~grp.group_event)) == 3'h0))
        else $error("ack clear failed");
    chk_bus_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!ack_cyc && (avs_read || avs_write)) |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_irq_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
        nxt_irq |=> irq) else $error("irq not raised");
    chk_req_gated: assert property (@(posedge sys_clk) disable iff (sys_rst)
        vreq_ff[1] |-> $past(global_en_ff) && $past(group_enable_reg_ff[1]))
        else $error("request without enables");
    chk_g0_request: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (group_flag_reg_ff[0] && group_enable_reg_ff[0] && global_en_ff && !vector_ack[0])
        |=> vreq_ff[0]) else $error("group 0 not requested");
    chk_g1_request: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (group_flag_reg_ff[1] && group_enable_reg_ff[1] && global_en_ff && !vector_ack[1])
        |=> vreq_ff[1]) else $error("group 1 not requested");
    chk_g2_request: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (group_flag_reg_ff[2] && group_enable_reg_ff[2] && global_en_ff && !vector_ack[2])
        |=> vreq_ff[2]) else $error("group 2 not requested");
    chk_mask1_bit7: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !group1_mask_reg_ff[7]) else $error("mask1 bit7 set");
    chk_mask_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !group0_mask_reg_ff[3] |-> !grp.pin_mask[3]) else $error("mask gate");
endmodule

// ---- verif/cpu_vector_model.sv ----
// Purpose: cpu side that enters the service routine of a requested vector
// Assumes: one clock; vector_req is a level
// Notes:   answer delay set by the bench, prompt or slow
`timescale 1ns/100ps
module cpu_vector_model (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              ack_en,
    input  wire logic [3:0]        ack_delay,
    input  wire watched_pin_pkg::group_t vector_req,
    input  wire logic [1:0]        vector_num,
    output watched_pin_pkg::group_t      vector_ack
);
    import watched_pin_pkg::*;
    logic [3:0] wait_ff;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_ff    <= 4'h0;
            vector_ack <= 3'h0;
        end else begin
            vector_ack <= 3'h0;
            // request lags the flag by a cycle, so restart the wait after each entry
            if (!ack_en || vector_req == 3'h0 || vector_ack != 3'h0) begin
                wait_ff <= 4'h0;
            end else if (wait_ff >= ack_delay) begin
                vector_ack <= group_t'(3'h1 << vector_num);
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule

// ---- verif/test_pin_change_irq.sv ----
// Purpose: self-checking bench of the pin change interrupt unit
// Assumes: register reads scored through a queue of expected bytes
// Notes:   pins chosen at random inside each group
`timescale 1ns/100ps
`include "watched_pin_params.svh"
module test_pin_change_irq;
    import watched_pin_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [9:0]  avs_address = 10'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    pins_t       watched_pin = 24'h0;
    group_t      vector_ack;
    group_t      vector_req;
    logic [1:0]  vector_num;
    logic        irq;
    logic        ack_en = 1'b0;
    logic [3:0]  ack_delay = 4'h2;
    integer      seed = 84873;
    int          fails = 0;
    int          n_tests = 0;
    int          cyc = 0;
    byte_t       exp_q[$];
    byte_t       regs[6] = '{`IDX_GROUP_ENABLE, `IDX_GROUP0_MASK, `IDX_GROUP1_MASK,
                             `IDX_GROUP2_MASK, `IDX_GROUP_FLAGS, 8'h10};
    byte_t       exp_ff[6] = '{8'h07, 8'hff, 8'h7f, 8'hff, 8'h00, 8'h00};

    pin_change_irq i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .watched_pin(watched_pin),
        .vector_ack(vector_ack), .vector_req(vector_req), .vector_num(vector_num), .irq(irq));
    cpu_vector_model i_cpu (.sys_clk(sys_clk), .sys_rst(sys_rst), .ack_en(ack_en),
        .ack_delay(ack_delay), .vector_req(vector_req), .vector_num(vector_num),
        .vector_ack(vector_ack));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_reg(input byte_t e, input logic [31:0] s);
        n_tests++;
        if ({24'h0, e} !== s) begin
            fails++;
            $display("[FAIL] readdata expected %h seen %h", e, s);
        end
    endtask

    task automatic chk_sig(input string nm, input logic [2:0] e, input logic [2:0] s);
        n_tests++;
        if (e !== s) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // ceiling well above the roughly 220 cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            chk_reg(exp_q.pop_front(), avs_readdata);
        end
    end

    task automatic bus_wr(input byte_t idx, input byte_t d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic bus_rd(input byte_t idx, input byte_t e);
        @(posedge sys_clk);
        exp_q.push_back(e);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
    endtask

    // a change needs five edges to reach vector_req and irq
    task automatic toggle(input int p);
        @(posedge sys_clk);
        watched_pin[p] <= ~watched_pin[p];
        repeat (7) @(posedge sys_clk);
    endtask

    initial begin
        int p;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (regs[i]) bus_rd(regs[i], 8'h00);
        foreach (regs[i]) bus_wr(regs[i], 8'hff, 4'hf);
        foreach (regs[i]) bus_rd(regs[i], exp_ff[i]);
        bus_wr(`IDX_GROUP_ENABLE, 8'h00, 4'h0);
        bus_rd(`IDX_GROUP_ENABLE, 8'h07);
        bus_wr(`IDX_CPU_CTRL, 8'h01, 4'hf);
        bus_wr(`IDX_IRQ_MASK, 8'h07, 4'hf);
        for (int g = 0; g < 3; g++) begin
            p = (g == 1) ? 8 + $unsigned($random(seed)) % 7 : 8 * g + $unsigned($random(seed)) % 8;
            toggle(p);
            chk_sig("vector_req", group_t'(1 << g), vector_req);
            chk_sig("vector_num", 3'(g), {1'b0, vector_num});
            chk_sig("irq", 3'h1, {2'b00, irq});
            bus_rd(`IDX_GROUP_FLAGS, byte_t'(1 << g));
            if (g == 0) begin
                bus_wr(`IDX_GROUP_FLAGS, 8'h06, 4'hf);
                bus_rd(`IDX_GROUP_FLAGS, 8'h01);
                bus_wr(`IDX_GROUP_FLAGS, 8'h01, 4'hf);
            end else begin
                ack_delay <= 4'(2 + $unsigned($random(seed)) % 8);
                ack_en <= 1'b1;
                repeat (14) @(posedge sys_clk);
                ack_en <= 1'b0;
            end
            repeat (3) @(posedge sys_clk);
            chk_sig("vector_req", 3'h0, vector_req);
            chk_sig("irq", 3'h0, {2'b00, irq});
            bus_rd(`IDX_GROUP_FLAGS, 8'h00);
        end
        bus_wr(`IDX_GROUP0_MASK, 8'h00, 4'hf);
        toggle($unsigned($random(seed)) % 8);
        bus_rd(`IDX_GROUP_FLAGS, 8'h00);
        p = $unsigned($random(seed)) % 8;
        bus_wr(`IDX_GROUP2_MASK, byte_t'(1 << p), 4'hf);
        toggle(16 + (p + 1) % 8);
        bus_rd(`IDX_GROUP_FLAGS, 8'h00);
        bus_wr(`IDX_CPU_CTRL, 8'h00, 4'hf);
        toggle(16 + p);
        chk_sig("vector_req", 3'h0, vector_req);
        bus_rd(`IDX_GROUP_FLAGS, 8'h04);
        bus_wr(`IDX_CPU_CTRL, 8'h01, 4'hf);
        repeat (3) @(posedge sys_clk);
        chk_sig("vector_req", 3'h4, vector_req);
        bus_wr(`IDX_IRQ_MASK, 8'h03, 4'hf);
        repeat (3) @(posedge sys_clk);
        chk_sig("irq", 3'h0, {2'b00, irq});
        close_out();
    end
endmodule
